// >>> core/dma_mac.sv
// multiply-accumulate datapath: multiplier, 40-bit adder/subtracter, two accumulators, saturation
// assumes the decoder presents one request per cycle with req_valid; status feeds the core status register
`timescale 1ns/1ps
module dma_mac
   import dma_pkg::*;
#(
   parameter int OPERAND_WIDTH = OPND_W,   // operand extension is built for 16-bit operands only
   parameter int ACCUM_WIDTH   = ACC_W     // clamps and guard slices assume 8 guard bits over 32
)
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              req_valid,
   input  wire dma_req_t          req,
   input  wire logic [7:0]        core_control_reg,
   input  wire logic              trap_enable_a,
   input  wire logic              trap_enable_b,
   input  wire logic              sat_clear,
   output logic [ACC_W-1:0]       accumulator_a,
   output logic [ACC_W-1:0]       accumulator_b,
   output logic [PROD_W-1:0]      gmul_result,
   output logic                   gmul_valid,
   output dma_status_t            status,
   output logic                   arith_warning_trap
);
   // accumulator state
   logic [ACC_W-1:0]              acc_a_reg;
   logic [ACC_W-1:0]              acc_a_next;
   logic [ACC_W-1:0]              acc_b_reg;
   logic [ACC_W-1:0]              acc_b_next;

   // general multiply result and its one-cycle strobe
   logic [PROD_W-1:0]             gmul_reg;
   logic [PROD_W-1:0]             gmul_next;
   logic                          gvld_reg;
   logic                          gvld_next;

   // warning trap and status flags
   logic                          trap_reg;
   logic                          trap_next;
   dma_status_t                   stat_reg;
   dma_status_t                   stat_next;

   // multiplier
   logic                          byte_op;
   logic signed [MULT_IN_W-1:0]   m_a;
   logic signed [MULT_IN_W-1:0]   m_b;
   logic signed [2*MULT_IN_W-1:0] m_full;
   logic [PROD_W-1:0]             product;
   logic [ACC_W-1:0]              prod_ext;

   // operand selection
   logic [ACC_W-1:0]              shifted;
   logic [ACC_W-1:0]              src;
   logic [ACC_W-1:0]              addend;
   logic                          use_zero;
   logic                          subtract;
   logic                          is_adder;

   // adder/subtracter
   logic [ACC_W-1:0]              left_in;
   logic [ACC_W-1:0]              right_in;
   logic                          carry_in;
   logic [ACC_W:0]                sum41;
   logic [ACC_W-1:0]              sum41_lo;

   // overflow detection
   logic                          true_sign;
   logic                          ovf39;
   logic                          guard_ovf;
   logic                          ovf31;

   // saturation
   logic                          sat_en;
   logic                          wide;
   logic                          do_sat;
   logic [ACC_W-1:0]              clamp;
   logic [ACC_W-1:0]              result;

   // the extension, clamp values and guard slices are fixed to these widths
   if (OPERAND_WIDTH != OPND_W || ACCUM_WIDTH != ACC_W) begin : g_width_check
      $error("dma_mac supports only 16-bit operands and a 40-bit accumulator");
   end

   // arithmetic shift right for positive counts, left for negative counts
   function automatic logic [ACC_W-1:0] barrel(input logic [ACC_W-1:0] d, input logic signed [SHIFT_W-1:0] s);
      logic [5:0] mag;
      mag = s[SHIFT_W-1] ? 6'(-s) : 6'(s);
      if (s[SHIFT_W-1])
         barrel = d << mag;
      else
         barrel = ACC_W'($signed(d) >>> mag);
   endfunction

   // widens one operand into the seventeenth multiplier bit; byte operands extend from their bit 7
   function automatic logic [MULT_IN_W-1:0] ext17(input logic [OPND_W-1:0] v,
                                                  input logic              sgn,
                                                  input logic              byte_sel);
      logic top;
      top = byte_sel ? v[BYTE_W-1] : v[OPND_W-1];
      if (byte_sel)
         ext17 = {{(MULT_IN_W-BYTE_W){sgn & top}}, v[BYTE_W-1:0]};
      else
         ext17 = {sgn & top, v};
   endfunction

   // true when the bits from lo up to the top are not all equal
   function automatic logic bits_mixed(input logic [ACC_W-1:0] v, input int lo);
      logic ones;
      logic zeros;
      ones  = 1'b1;
      zeros = 1'b1;
      for (int i = 0; i < ACC_W; i++) begin
         if (i >= lo) begin
            ones  = ones & v[i];
            zeros = zeros & ~v[i];
         end
      end
      bits_mixed = !(ones | zeros);
   endfunction

   // extreme value of the selected saturation width
   function automatic logic [ACC_W-1:0] clamp_value(input logic wide_mode, input logic negative);
      if (wide_mode)
         clamp_value = negative ? SAT_NEG_WIDE : SAT_POS_WIDE;
      else
         clamp_value = negative ? SAT_NEG_NARROW : SAT_POS_NARROW;
   endfunction

   // multiplier: one 17x17 array serves every mode, the extension alone picks the sign handling
   always_comb begin
      byte_op = req.byte_mode && (req.op == DMA_OP_GMUL);
      m_a     = ext17(req.opnd_a, req.a_signed, byte_op);
      m_b     = ext17(req.opnd_b, req.b_signed, byte_op);
      m_full  = m_a * m_b;
      // Q15 times Q15 carries two sign bits; one left shift lands the product in 1.31
      if (req.frac_mode)
         product = {m_full[PROD_W-2:0], 1'b0};
      else
         product = m_full[PROD_W-1:0];
      prod_ext = {{(ACC_W-PROD_W){product[PROD_W-1]}}, product};
   end

   // operand selection per operation
   always_comb begin
      shifted  = barrel(req.data_in, req.shift);
      src      = req.acc_sel ? acc_b_reg : acc_a_reg;
      use_zero = 1'b0;
      subtract = 1'b0;
      is_adder = 1'b1;
      addend   = prod_ext;
      case (req.op)
         DMA_OP_MAC: begin
            addend = prod_ext;
         end
         DMA_OP_MSC: begin
            addend   = prod_ext;
            subtract = 1'b1;
         end
         DMA_OP_MPY: begin
            addend   = prod_ext;
            use_zero = 1'b1;
         end
         DMA_OP_ADD: begin
            addend = shifted;
         end
         DMA_OP_SUB: begin
            addend   = shifted;
            subtract = 1'b1;
         end
         DMA_OP_LOAD: begin
            addend   = shifted;
            use_zero = 1'b1;
         end
         default: begin
            is_adder = 1'b0;
         end
      endcase
   end

   // adder/subtracter: subtract feeds inverted data with the borrow-low carry held at one
   always_comb begin
      left_in  = use_zero ? {ACC_W{1'b0}} : src;
      right_in = subtract ? ~addend : addend;
      carry_in = subtract;
      sum41    = {1'b0, left_in} + {1'b0, right_in} + {{ACC_W{1'b0}}, carry_in};
      sum41_lo = sum41[ACC_W-1:0];
   end

   // overflow: the sign of the exact result is both input sign bits XOR bit 40 of the widened sum
   always_comb begin
      true_sign = left_in[ACC_W-1] ^ right_in[ACC_W-1] ^ sum41[ACC_W];
      ovf39     = (left_in[ACC_W-1] == right_in[ACC_W-1])
                  && (sum41_lo[ACC_W-1] != left_in[ACC_W-1]);
      guard_ovf = ovf39 || bits_mixed(sum41_lo, GUARD_LO);
      // bit 31 no longer holds the sign once bits 31 up to 39 disagree
      ovf31     = ovf39 || bits_mixed(sum41_lo, NARROW_MSB);
   end

   // saturation: narrow mode clamps on a bit 31 overflow, wide mode only when bit 39 is lost
   always_comb begin
      sat_en = req.acc_sel ? core_control_reg[CTL_SAT_B] : core_control_reg[CTL_SAT_A];
      wide   = core_control_reg[CTL_SAT_WIDE];
      do_sat = is_adder && sat_en && (wide ? ovf39 : ovf31);
      clamp  = clamp_value(wide, true_sign);
      result = do_sat ? clamp : sum41_lo;
   end

   always_comb begin
      acc_a_next = acc_a_reg;
      acc_b_next = acc_b_reg;
      stat_next  = stat_reg;
      gmul_next  = gmul_reg;
      gvld_next  = 1'b0;
      trap_next  = 1'b0;
      if (sat_clear) begin
         stat_next.acc_a_saturated = 1'b0;
         stat_next.acc_b_saturated = 1'b0;
      end
      if (req_valid && req.op == DMA_OP_GMUL) begin
         // byte operands give a 16-bit result with upper half cleared
         gmul_next = req.byte_mode ? {16'h0000, m_full[15:0]} : m_full[PROD_W-1:0];
         gvld_next = 1'b1;
      end
      if (req_valid && is_adder) begin
         if (req.acc_sel) begin
            acc_b_next = result;
            stat_next.acc_b_guard_overflow = guard_ovf;
            stat_next.acc_b_catastrophic = ovf39;
            if (do_sat)
               stat_next.acc_b_saturated = 1'b1;
         end else begin
            acc_a_next = result;
            stat_next.acc_a_guard_overflow = guard_ovf;
            stat_next.acc_a_catastrophic = ovf39;
            if (do_sat)
               stat_next.acc_a_saturated = 1'b1;
         end
      end
      stat_next.either_guard_overflow = stat_next.acc_a_guard_overflow | stat_next.acc_b_guard_overflow;
      stat_next.either_saturated = stat_next.acc_a_saturated | stat_next.acc_b_saturated;
      trap_next = (stat_next.acc_a_guard_overflow & trap_enable_a)
                | (stat_next.acc_b_guard_overflow & trap_enable_b);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         acc_a_reg <= ACC_RESET;
         acc_b_reg <= ACC_RESET;
         gmul_reg  <= '0;
         gvld_reg  <= 1'b0;
         trap_reg  <= 1'b0;
         stat_reg  <= '0;
      end else begin
         acc_a_reg <= acc_a_next;
         acc_b_reg <= acc_b_next;
         gmul_reg  <= gmul_next;
         gvld_reg  <= gvld_next;
         trap_reg  <= trap_next;
         stat_reg  <= stat_next;
      end
   end

   assign accumulator_a      = acc_a_reg;
   assign accumulator_b      = acc_b_reg;
   assign gmul_result        = gmul_reg;
   assign gmul_valid         = gvld_reg;
   assign status             = stat_reg;
   assign arith_warning_trap = trap_reg;
endmodule // dma_mac

// >>> core/dma_pkg.sv
// package for the multiply-accumulate datapath: widths, modes, control bit positions, carriers
// assumes a single core clock and an instruction decoder that drives one operation per cycle
// Contract
// - 17x17 multiplier, fractional 1.31 or integer product
// - unsigned operands zero-fill seventeenth bit
// - signed operands sign-fill seventeenth bit
// - integer operands are 16-bit two's complement
// - fractional operands Q15, product 1.31
// - same multiplier serves general multiply instructions
// - byte multiply gives 16 bits, word 32
// - 40-bit adder, accumulator A or B
// - add and load data optionally barrel shifted
// - one input zeroable, other true or complemented
// - add carry active high, subtract borrow low
// - detect overflow out of bit 39
// - flag guard bits 32-39 not identical
// - overflow and saturation flags latched in status
// - saturation uses result, flags, control bits 7:6,4
// - saturation flag on bit 31 or 39 saturation
// - combined overflow and saturation flags are ORs
// - guard flag rewritten on every adder pass
// - guard flag with trap enable raises warning
package dma_pkg;
   localparam int ACC_W        = 40;
   localparam int PROD_W       = 32;
   localparam int OPND_W       = 16;
   localparam int MULT_IN_W    = 17;
   localparam int SHIFT_W      = 6;
   localparam int CTL_SAT_A    = 7;
   localparam int CTL_SAT_B    = 6;
   localparam int CTL_SAT_WIDE = 4;
   localparam int GUARD_LO     = 32;
   localparam int NARROW_MSB   = 31;
   localparam int BYTE_W       = 8;
   localparam logic [ACC_W-1:0] SAT_POS_WIDE   = 40'h7F_FFFF_FFFF;
   localparam logic [ACC_W-1:0] SAT_NEG_WIDE   = 40'h80_0000_0000;
   localparam logic [ACC_W-1:0] SAT_POS_NARROW = 40'h00_7FFF_FFFF;
   localparam logic [ACC_W-1:0] SAT_NEG_NARROW = 40'hFF_8000_0000;
   localparam logic [ACC_W-1:0] ACC_RESET = 40'h00_0000_0000;

   typedef enum logic [2:0] {
      DMA_OP_NOP, DMA_OP_MAC, DMA_OP_MSC, DMA_OP_MPY, DMA_OP_ADD, DMA_OP_SUB, DMA_OP_LOAD, DMA_OP_GMUL
   } dma_op_t;

   typedef struct packed {
      dma_op_t               op;
      logic                  acc_sel;     // 0 selects A, 1 selects B
      logic                  a_signed;
      logic                  b_signed;
      logic                  frac_mode;
      logic                  byte_mode;   // general multiply on byte operands
      logic [OPND_W-1:0]     opnd_a;
      logic [OPND_W-1:0]     opnd_b;
      logic [ACC_W-1:0]      data_in;     // add/sub/load data, barrel shifted by shift before the adder
      logic signed [SHIFT_W-1:0] shift;   // positive shifts right, negative left
   } dma_req_t;

   typedef struct packed {
      logic acc_a_guard_overflow;
      logic acc_b_guard_overflow;
      logic acc_a_saturated;
      logic acc_b_saturated;
      logic either_guard_overflow;
      logic either_saturated;
      logic acc_a_catastrophic;
      logic acc_b_catastrophic;
   } dma_status_t;
endpackage

// >>> tb/dma_mac_sva.sv
// port checker for dma_mac
// assumes one clock and async active-high reset
`timescale 1ns/1ps
module dma_mac_sva
   import dma_pkg::*;
(
   input wire logic              clk,
   input wire logic              reset,
   input wire logic              req_valid,
   input wire dma_req_t          req,
   input wire logic [7:0]        core_control_reg,
   input wire logic              trap_enable_a,
   input wire logic              trap_enable_b,
   input wire logic              sat_clear,
   input wire logic [ACC_W-1:0]  accumulator_a,
   input wire logic [ACC_W-1:0]  accumulator_b,
   input wire logic [PROD_W-1:0] gmul_result,
   input wire logic              gmul_valid,
   input wire dma_status_t       status,
   input wire logic              arith_warning_trap
);
   logic signed [ACC_W-1:0] prod_s;
   assign prod_s = $signed(req.opnd_a) * $signed(req.opnd_b);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence gmul_s; req_valid && req.op == DMA_OP_GMUL; endsequence
   sequence mpy_s; req_valid && req.op == DMA_OP_MPY && !req.acc_sel && !req.frac_mode; endsequence
   gmul_pulse_a: assert property (gmul_s |=> gmul_valid) else $error("gmul pulse");
   byte_width_a: assert property (gmul_s ##0 req.byte_mode |=> gmul_result[31:16] == 16'h0000) else $error("byte");
   mpy_load_a: assert property (mpy_s ##0 (req.a_signed && req.b_signed && !core_control_reg[7])
      |=> accumulator_a == $past(prod_s)) else $error("mpy");
   b_untouched_a: assert property (req_valid && !req.acc_sel |=> $stable(accumulator_b)) else $error("acc b");
   acc_hold_a: assert property (!req_valid |=> $stable(accumulator_a)) else $error("acc a");
   either_ovf_a: assert property (status.either_guard_overflow == (status.acc_a_guard_overflow
      | status.acc_b_guard_overflow)) else $error("either");
   trap_lag_a: assert property (arith_warning_trap == (status.acc_a_guard_overflow & $past(trap_enable_a)
      | status.acc_b_guard_overflow & $past(trap_enable_b))) else $error("trap");
   sat_sticky_a: assert property (status.acc_a_saturated && !sat_clear |=> status.acc_a_saturated) else $error("sat");
endmodule // dma_mac_sva
bind dma_mac dma_mac_sva chk (.clk(clk), .reset(reset), .req_valid(req_valid), .req(req),
   .core_control_reg(core_control_reg), .trap_enable_a(trap_enable_a), .trap_enable_b(trap_enable_b),
   .sat_clear(sat_clear), .accumulator_a(accumulator_a), .accumulator_b(accumulator_b), .gmul_result(gmul_result),
   .gmul_valid(gmul_valid), .status(status), .arith_warning_trap(arith_warning_trap));

// >>> tb/dma_mac_tb.sv
// self-checking bench for dma_mac
// assumes dma_wreg stands in for the working registers
`timescale 1ns/1ps
module dma_mac_tb;
   import dma_pkg::*;
   logic clk = 1'b0, reset = 1'b1, rv = 1'b0, te_a = 1'b0, te_b = 1'b0, sclr = 1'b0, gval, trap;
   logic [7:0] ctl = 8'h00;
   dma_req_t req = '0;
   logic [ACC_W-1:0] acc_a, acc_b;
   logic [PROD_W-1:0] gres, wreg;
   dma_status_t st;
   int errors = 0, compares = 0;
   always #12.5 clk = ~clk;
   dma_mac dut (.clk(clk), .reset(reset), .req_valid(rv), .req(req), .core_control_reg(ctl),
      .trap_enable_a(te_a), .trap_enable_b(te_b), .sat_clear(sclr), .accumulator_a(acc_a), .accumulator_b(acc_b),
      .gmul_result(gres), .gmul_valid(gval), .status(st), .arith_warning_trap(trap));
   dma_wreg wr (.clk(clk), .gmul_valid(gval), .gmul_result(gres), .wreg(wreg));
   task automatic check(logic [ACC_W-1:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic run(dma_op_t op, logic sel, sa, sb, fr, by, logic [15:0] a, b, logic [39:0] d, int sh);
      @(posedge clk);
      rv <= 1'b1;
      req <= '{op, sel, sa, sb, fr, by, a, b, d, 6'(sh)};
      @(posedge clk);
      rv <= 1'b0;
      #1;
   endtask
   task automatic gm(logic sa, sb, by, logic [15:0] a, b, logic [31:0] exp);
      run(DMA_OP_GMUL, 0, sa, sb, 0, by, a, b, 0, 0);
      check(gval, 1);
      check(gres, exp);
      @(posedge clk) #1 check(wreg, exp);
   endtask
   task automatic ld_add(logic [39:0] x, y);
      run(DMA_OP_LOAD, 0, 0, 0, 0, 0, 0, 0, x, 0);
      run(DMA_OP_ADD, 0, 0, 0, 0, 0, 0, 0, y, 0);
   endtask
   task automatic t_mult;
      gm(0, 0, 0, 16'hFFFF, 16'hFFFF, 32'hFFFE0001);
      gm(1, 1, 0, 16'hFFFF, 16'hFFFF, 32'h00000001);
      gm(1, 0, 0, 16'hFFFF, 16'hFFFF, 32'hFFFF0001);
      gm(0, 0, 1, 16'h00FF, 16'h00FF, 32'h0000FE01);
   endtask
   task automatic t_mac;
      run(DMA_OP_MAC, 0, 1, 1, 1, 0, 16'h4000, 16'h4000, 0, 0);
      check(acc_a, 40'h0020000000);
      run(DMA_OP_MSC, 0, 1, 1, 1, 0, 16'h4000, 16'h4000, 0, 0);
      check(acc_a, 40'h0000000000);
      run(DMA_OP_MPY, 1, 1, 1, 0, 0, 16'h8000, 16'h7FFF, 0, 0);
      check(acc_b, 40'hFFC0008000);
      run(DMA_OP_MPY, 0, 1, 1, 0, 0, 16'h8000, 16'h8000, 0, 0);
      check(acc_a, 40'h0040000000);
   endtask
   task automatic t_guard;
      @(posedge clk) te_a <= 1'b1;
      ld_add(40'h007FFFFFFF, 40'h0080000001);
      check(acc_a, 40'h0100000000);
      check(st.acc_a_guard_overflow, 1);
      check(st.either_guard_overflow, 1);
      @(posedge clk) #1 check(trap, 1);
      run(DMA_OP_LOAD, 0, 0, 0, 0, 0, 0, 0, 40'h1, -4);
      check(acc_a, 40'h10);
      check(st.acc_a_guard_overflow, 0);
   endtask
   task automatic t_sat;
      @(posedge clk) ctl <= 8'h80;
      ld_add(40'h007FFFFFFF, 40'h1);
      check(acc_a, 40'h007FFFFFFF);
      check(st.acc_a_saturated, 1);
      run(DMA_OP_LOAD, 0, 0, 0, 0, 0, 0, 0, 0, 0);
      check(st.either_saturated, 1);
      @(posedge clk) sclr <= 1'b1;
      @(posedge clk) sclr <= 1'b0;
      #1 check(st.acc_a_saturated, 0);
      @(posedge clk) ctl <= 8'h90;
      ld_add(40'h7FFFFFFFFF, 40'h1);
      check(acc_a, 40'h7FFFFFFFFF);
      @(posedge clk) ctl <= 8'h10;
      ld_add(40'h7FFFFFFFFF, 40'h1);
      check(st.acc_a_catastrophic, 1);
   endtask
   task automatic t_accumulator_b;
      @(posedge clk) begin
         ctl <= 8'h40;
         te_a <= 1'b0;
         te_b <= 1'b1;
      end
      run(DMA_OP_LOAD, 1, 0, 0, 0, 0, 0, 0, 40'h007FFFFFFF, 0);
      run(DMA_OP_ADD, 1, 0, 0, 0, 0, 0, 0, 40'h1, 0);
      check(acc_b, 40'h007FFFFFFF);
      check(st.acc_b_saturated, 1);
      @(posedge clk) ctl <= 8'h00;
      run(DMA_OP_LOAD, 1, 0, 0, 0, 0, 0, 0, 40'h00FFFFFFFF, 0);
      run(DMA_OP_ADD, 1, 0, 0, 0, 0, 0, 0, 40'h1, 0);
      check(acc_b, 40'h0100000000);
      check(st.acc_b_guard_overflow, 1);
      check(trap, 1);
      run(DMA_OP_SUB, 1, 0, 0, 0, 0, 0, 0, 40'h1, 0);
      check(acc_b, 40'h00FFFFFFFF);
      check(st.acc_b_guard_overflow, 0);
      check(trap, 0);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_mult;
      t_mac;
      t_guard;
      t_sat;
      t_accumulator_b;
      conclude;
   end
   // generous against the roughly sixty cycles the scenarios need
   initial begin
      #20000;
      errors++;
      conclude;
   end
endmodule // dma_mac_tb

// >>> tb/dma_wreg.sv
// working register model: keeps the last general multiply result
// assumes gmul_valid is a one-cycle pulse
`timescale 1ns/1ps
module dma_wreg
   import dma_pkg::*;
(
   input wire logic              clk,
   input wire logic              gmul_valid,
   input wire logic [PROD_W-1:0] gmul_result,
   output logic [PROD_W-1:0]     wreg
);
   // taken on the pulse only, the result port is not trusted outside it
   always @(posedge clk) if (gmul_valid) wreg <= gmul_result;
endmodule // dma_wreg
